//--- core/gpio_sense_pkg.sv
// package for the gpio pin configuration and sense latch block
// assumes a 32-bit avalon-mm register bus and a single system clock
package gpio_sense_pkg;
  localparam int          NUM_PINS     = 32;   // pins on the port
  localparam int          NUM_CFG      = 2;    // pins with a configuration word here
  // byte addresses of the registers
  localparam logic [11:0] ADDR_LATCH   = 12'h520;
  localparam logic [11:0] ADDR_DETMODE = 12'h524;
  localparam logic [11:0] ADDR_CFG0    = 12'h700;
  localparam logic [11:0] ADDR_CFG1    = 12'h704;
  localparam logic [11:0] ADDR_DIR     = 12'h514;
  localparam logic [11:0] ADDR_IRQ_ST  = 12'h530;
  localparam logic [11:0] ADDR_IRQ_MSK = 12'h534;
  // reset values
  localparam logic [31:0] CFG_RESET    = 32'h0000_0002;
  localparam logic [31:0] ZERO32       = 32'h0000_0000;
  // configuration word field positions
  localparam int          F_DIR        = 0;
  localparam int          F_INBUF      = 1;
  localparam int          F_PULL_LO    = 2;
  localparam int          F_PULL_HI    = 3;
  localparam int          F_DRV_LO     = 8;
  localparam int          F_DRV_HI     = 10;
  localparam int          F_SNS_LO     = 16;
  localparam int          F_SNS_HI     = 17;
  localparam int          F_MODE       = 0;
  // stored bits of a configuration word (bit 0 lives in the direction vector)
  localparam logic [31:0] CFG_MASK     = 32'h0003_070E;
  // sense encodings
  localparam logic [1:0]  SNS_OFF      = 2'h0;
  localparam logic [1:0]  SNS_HIGH     = 2'h2;
  localparam logic [1:0]  SNS_LOW      = 2'h3;
  // pull encodings
  localparam logic [1:0]  PULL_DOWN    = 2'h1;
  localparam logic [1:0]  PULL_UP      = 2'h3;
  // drive encodings
  localparam logic [2:0]  std_low_std_high       = 3'h0;
  localparam logic [2:0]  strong_low_std_high    = 3'h1;
  localparam logic [2:0]  std_low_strong_high    = 3'h2;
  localparam logic [2:0]  strong_low_strong_high = 3'h3;
  localparam logic [2:0]  open_low_std_high      = 3'h4;
  localparam logic [2:0]  open_low_strong_high   = 3'h5;
  localparam logic [2:0]  std_low_open_high      = 3'h6;
  localparam logic [2:0]  strong_low_open_high   = 3'h7;
  // interrupt status bits
  localparam int          IRQ_DETECT   = 0;
  localparam int          IRQ_LATCH    = 1;
endpackage

//--- core/pin_driver.sv
// pad control decode for one configured pin: drive strength, pull, buffer
// assumes the pad cell takes separate enable and strength controls
module pin_driver
  import gpio_sense_pkg::*;
(
  // configuration
  input  wire logic       dir_i,
  input  wire logic       out_i,
  input  wire logic [2:0] drive_i,
  input  wire logic [1:0] pull_i,
  input  wire logic       inbuf_dis_i,
  // pad controls
  output logic            oe_o,
  output logic            strong_o,
  output logic            pull_up_o,
  output logic            pull_down_o,
  output logic            inbuf_en_o
);
  logic low_open;   // low level left undriven
  logic high_open;  // high level left undriven
  logic low_hi;     // high strength on low level
  logic high_hi;    // high strength on high level

  // strength table per level
  always_comb begin
    low_open  = 1'b0;
    high_open = 1'b0;
    low_hi    = 1'b0;
    high_hi   = 1'b0;
    case (drive_i)
      std_low_std_high:       begin end
      strong_low_std_high:    low_hi  = 1'b1;
      std_low_strong_high:    high_hi = 1'b1;
      strong_low_strong_high: begin low_hi = 1'b1; high_hi = 1'b1; end
      open_low_std_high:      low_open = 1'b1;
      open_low_strong_high:   begin low_open = 1'b1; high_hi = 1'b1; end
      std_low_open_high:      high_open = 1'b1;
      strong_low_open_high:   begin high_open = 1'b1; low_hi = 1'b1; end
      default:                begin end
    endcase
  end

  // output enable follows direction and the level being driven
  assign oe_o        = dir_i & (out_i ? ~high_open : ~low_open);
  assign strong_o    = out_i ? high_hi : low_hi;
  assign pull_up_o   = (pull_i == PULL_UP);
  assign pull_down_o = (pull_i == PULL_DOWN);
  assign inbuf_en_o  = ~inbuf_dis_i;
endmodule // pin_driver

//--- core/pin_sense.sv
// level sense decode for one pin from its two-bit sense field
// assumes the pin level is already synchronised
module pin_sense
  import gpio_sense_pkg::*;
(
  input  wire logic [1:0] sense_i,  // sense field
  input  wire logic       level_i,  // synchronised pin level
  output logic            det_o     // criterion met
);
  // value 1 is not defined and senses nothing, like disabled
  always_comb begin
    case (sense_i)
      SNS_HIGH: det_o = level_i;
      SNS_LOW:  det_o = ~level_i;
      default:  det_o = 1'b0;
    endcase
  end
endmodule // pin_sense

//--- core/gpio_sense_top.sv
// gpio pin configuration, level sense and sense latch with avalon-mm slave
// assumes pins arrive asynchronously and pass a two-stage synchroniser
// Function
// - writing one clears latch bit; zero keeps
// - one latch bit per pin, resets zero
// - direction bit shared with direction register
// - input buffer bit; config resets 0x2
// - drive values 0-3 select strengths
// - drive 4,5 leave low undriven
// - drive 6,7 leave high undriven
// - sense 0 off, 2 high, 3 low
//
// The implementer's own choice: register access over Avalon-MM.
module gpio_sense_top
  import gpio_sense_pkg::*;
(
  // clock, reset, enable
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                ce_i,
  // avalon-mm slave
  input  wire logic [11:0]         address_i,
  input  wire logic                read_i,
  input  wire logic                write_i,
  input  wire logic [3:0]          byteenable_i,
  input  wire logic [31:0]         writedata_i,
  output logic      [31:0]         readdata_o,
  output logic                     waitrequest_o,
  // pins
  input  wire logic [NUM_PINS-1:0] pin_i,
  input  wire logic [NUM_PINS-1:0] pin_out_i,
  output logic      [NUM_PINS-1:0] pin_oe_o,
  output logic      [NUM_PINS-1:0] pin_strong_o,
  output logic      [NUM_PINS-1:0] pin_pull_up_o,
  output logic      [NUM_PINS-1:0] pin_pull_down_o,
  output logic      [NUM_PINS-1:0] pin_inbuf_en_o,
  // detect and interrupt
  output logic                     detect_o,
  output logic                     irq_o
);
  // all state of the block
  typedef struct packed {
    logic [NUM_PINS-1:0] sync1;    // first synchroniser stage
    logic [NUM_PINS-1:0] sync2;    // second synchroniser stage
    logic [NUM_PINS-1:0] dir;      // direction, shared with config bit 0
    logic [NUM_PINS-1:0] latch;    // sense latch status
    logic [NUM_CFG-1:0][31:0] cfg; // configuration words, dir bit held apart
    logic                mode;     // detect mode select
    logic [1:0]          irq_st;   // sticky interrupt status
    logic [1:0]          irq_msk;  // interrupt mask
    logic                det;      // registered detect output
    logic                ack;      // access answered this cycle
    logic [31:0]         rdata;    // read data
  } state_t;

  state_t s_q;  // registered state
  state_t s_d;  // next state

  logic [NUM_PINS-1:0] det_live;   // per-pin live detect
  logic [NUM_PINS-1:0] cfg_oe;     // per-pin output enable from decode

  // byte-enable merge used by the direction and configuration registers
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[b*8 +: 8] = wd[b*8 +: 8];
    end
    return r;
  endfunction

  // expanded write mask from byte enables
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    logic [31:0] m;
    m = ZERO32;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) m[b*8 +: 8] = 8'hFF;
    end
    return m;
  endfunction

  // pins without a configuration word sense nothing and drive with defaults
  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : g_pin
      logic [31:0] word;  // effective configuration word
      if (g < NUM_CFG) begin : g_cfg
        assign word = s_q.cfg[g];
      end else begin : g_dflt
        assign word = CFG_RESET;
      end
      pin_sense u_sense (
        .sense_i (word[F_SNS_HI:F_SNS_LO]),
        .level_i (s_q.sync2[g]),
        .det_o   (det_live[g])
      );
      pin_driver u_drv (
        .dir_i       (s_q.dir[g]),
        .out_i       (pin_out_i[g]),
        .drive_i     (word[F_DRV_HI:F_DRV_LO]),
        .pull_i      (word[F_PULL_HI:F_PULL_LO]),
        .inbuf_dis_i (word[F_INBUF]),
        .oe_o        (cfg_oe[g]),
        .strong_o    (pin_strong_o[g]),
        .pull_up_o   (pin_pull_up_o[g]),
        .pull_down_o (pin_pull_down_o[g]),
        .inbuf_en_o  (pin_inbuf_en_o[g])
      );
    end
  endgenerate

  // next-state logic: synchroniser, latch, bus slave, interrupts
  always_comb begin
    logic        acc;       // request seen this cycle
    logic        wr;        // write taken
    logic [31:0] wmask;     // byte-lane mask
    logic        det_next;  // detect value for next cycle
    acc      = 1'b0;
    wr       = 1'b0;
    wmask    = ZERO32;
    det_next = 1'b0;
    s_d      = s_q;
    if (ce_i) begin
      s_d.sync1 = pin_i;
      s_d.sync2 = s_q.sync1;
      acc   = (read_i | write_i) & ~s_q.ack;
      wr    = write_i & acc;
      wmask = be_mask(byteenable_i);
      s_d.ack   = acc;
      s_d.rdata = ZERO32;
      // register writes
      if (wr) begin
        case (address_i)
          ADDR_LATCH: s_d.latch = s_q.latch & ~(writedata_i & wmask);
          // the mode bit sits in lane 0; a write without that lane keeps it
          ADDR_DETMODE: if (wmask[F_MODE]) s_d.mode = writedata_i[F_MODE];
          ADDR_DIR: s_d.dir = merge(s_q.dir, writedata_i, byteenable_i);
          ADDR_CFG0: begin
            s_d.cfg[0] = merge(s_q.cfg[0], writedata_i, byteenable_i) & CFG_MASK;
            if (wmask[F_DIR]) s_d.dir[0] = writedata_i[F_DIR];
          end
          ADDR_CFG1: begin
            s_d.cfg[1] = merge(s_q.cfg[1], writedata_i, byteenable_i) & CFG_MASK;
            if (wmask[F_DIR]) s_d.dir[1] = writedata_i[F_DIR];
          end
          ADDR_IRQ_ST:  s_d.irq_st  = s_q.irq_st & ~writedata_i[1:0];
          ADDR_IRQ_MSK: s_d.irq_msk = writedata_i[1:0];
          default: begin end
        endcase
      end
      // register reads
      if (read_i & acc) begin
        case (address_i)
          ADDR_LATCH:   s_d.rdata = s_q.latch;
          ADDR_DETMODE: s_d.rdata = {31'h0, s_q.mode};
          ADDR_DIR:     s_d.rdata = s_q.dir;
          ADDR_CFG0:    s_d.rdata = s_q.cfg[0] | {31'h0, s_q.dir[0]};
          ADDR_CFG1:    s_d.rdata = s_q.cfg[1] | {31'h0, s_q.dir[1]};
          ADDR_IRQ_ST:  s_d.rdata = {30'h0, s_q.irq_st};
          ADDR_IRQ_MSK: s_d.rdata = {30'h0, s_q.irq_msk};
          default:      s_d.rdata = ZERO32;  // unmapped reads as zero
        endcase
      end
      // setting wins over a same-cycle clear
      s_d.latch = s_d.latch | det_live;
      // detect source chosen by mode
      det_next = s_q.mode ? (|s_q.latch) : (|det_live);
      s_d.det  = det_next;
      // sticky events, set wins over clear
      if (det_next & ~s_q.det) s_d.irq_st[IRQ_DETECT] = 1'b1;
      if (|(det_live & ~s_q.latch)) s_d.irq_st[IRQ_LATCH] = 1'b1;
    end
  end

  // single state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q.sync1   <= '0;
      s_q.sync2   <= '0;
      s_q.dir     <= '0;
      s_q.latch   <= '0;
      s_q.cfg     <= {NUM_CFG{CFG_RESET & CFG_MASK}};
      s_q.mode    <= 1'b0;
      s_q.irq_st  <= 2'h0;
      s_q.irq_msk <= 2'h0;
      s_q.det     <= 1'b0;
      s_q.ack     <= 1'b0;
      s_q.rdata   <= ZERO32;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs
  // a frozen ack must not answer a request that the frozen logic never took
  assign waitrequest_o = (read_i | write_i) & ~(s_q.ack & ce_i);
  assign readdata_o    = s_q.rdata;
  assign detect_o      = s_q.det;
  assign irq_o         = |(s_q.irq_st & s_q.irq_msk);
  assign pin_oe_o      = cfg_oe;

  // assertions
  // a request is taken at the edge where it meets a clear ack flop
  sequence s_taken;
    ce_i && (read_i || write_i) && waitrequest_o;
  endsequence
  sequence s_taken_write;
    ce_i && write_i && waitrequest_o;
  endsequence

  property p_clear_one;
    @(posedge clk_i) disable iff (rst_i)
      (s_taken_write ##0 (address_i == ADDR_LATCH && byteenable_i[0]
       && writedata_i[0] && !det_live[0]))
      |=> !s_q.latch[0];
  endproperty
  a_clear_one: assert property (p_clear_one) else $error("latch bit not cleared");

  property p_zero_keeps;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && s_q.latch[0] && !(write_i && waitrequest_o && address_i == ADDR_LATCH
       && byteenable_i[0] && writedata_i[0]))
      |=> s_q.latch[0];
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("latch bit lost");

  property p_latch_sets;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && det_live[0]) |=> s_q.latch[0];
  endproperty
  a_latch_sets: assert property (p_latch_sets) else $error("latch not set");

  property p_live_mode;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && !s_q.mode) |=> (detect_o == |$past(det_live));
  endproperty
  a_live_mode: assert property (p_live_mode) else $error("live detect wrong");

  property p_latch_mode;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && s_q.mode) |=> (detect_o == |$past(s_q.latch));
  endproperty
  a_latch_mode: assert property (p_latch_mode) else $error("latched detect wrong");

  property p_dir_shared;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && write_i && !waitrequest_o && address_i == ADDR_CFG0 && byteenable_i[0])
      |=> (s_q.dir[0] == $past(writedata_i[F_DIR]));
  endproperty
  a_dir_shared: assert property (p_dir_shared) else $error("direction not shared");

  property p_inbuf;
    @(posedge clk_i) disable iff (rst_i)
      pin_inbuf_en_o[0] == !s_q.cfg[0][F_INBUF];
  endproperty
  a_inbuf: assert property (p_inbuf) else $error("input buffer wrong");

  property p_open_low;
    @(posedge clk_i) disable iff (rst_i)
      (s_q.cfg[0][F_DRV_HI] && !s_q.cfg[0][F_DRV_HI-1] && !pin_out_i[0])
      |-> !pin_oe_o[0];
  endproperty
  a_open_low: assert property (p_open_low) else $error("low driven in wired-or");

  property p_open_high;
    @(posedge clk_i) disable iff (rst_i)
      (s_q.cfg[0][F_DRV_HI:F_DRV_HI-1] == 2'h3 && pin_out_i[0]) |-> !pin_oe_o[0];
  endproperty
  a_open_high: assert property (p_open_high) else $error("high driven in wired-and");

  property p_sense_off;
    @(posedge clk_i) disable iff (rst_i)
      (s_q.cfg[1][F_SNS_HI:F_SNS_LO] == SNS_OFF) |-> !det_live[1];
  endproperty
  a_sense_off: assert property (p_sense_off) else $error("disabled sense fired");

  property p_pull_up;
    @(posedge clk_i) disable iff (rst_i)
      (s_q.cfg[0][F_PULL_HI:F_PULL_LO] == PULL_UP) |-> (pin_pull_up_o[0] && !pin_pull_down_o[0]);
  endproperty
  a_pull_up: assert property (p_pull_up) else $error("pull-up wrong");

  // the answer comes exactly one cycle after the request is taken
  property p_one_wait;
    @(posedge clk_i) disable iff (rst_i)
      (s_taken ##1 (ce_i && (read_i || write_i))) |-> !waitrequest_o;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("answer not after one wait");

  // a low enable freezes every state bit, synchroniser included
  property p_freeze;
    @(posedge clk_i) disable iff (rst_i)
      !ce_i |=> $stable(s_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while disabled");

  // the mode bit takes the written value when its lane is enabled
  property p_mode_write;
    @(posedge clk_i) disable iff (rst_i)
      (s_taken_write ##0 (address_i == ADDR_DETMODE && byteenable_i[0]))
      |=> (s_q.mode == $past(writedata_i[F_MODE]));
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("detect mode not written");

  // a read of the latch returns the status held when the read was taken
  property p_latch_read;
    @(posedge clk_i) disable iff (rst_i)
      (s_taken ##0 (read_i && address_i == ADDR_LATCH))
      |=> (readdata_o == $past(s_q.latch));
  endproperty
  a_latch_read: assert property (p_latch_read) else $error("latch read wrong");

  // a newly met criterion raises the sticky latch event
  property p_latch_event;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && |(det_live & ~s_q.latch)) |=> s_q.irq_st[IRQ_LATCH];
  endproperty
  a_latch_event: assert property (p_latch_event) else $error("latch event lost");

  property p_strong_both;
    @(posedge clk_i) disable iff (rst_i)
      (s_q.dir[0] && s_q.cfg[0][F_DRV_HI:F_DRV_LO] == strong_low_strong_high)
      |-> (pin_oe_o[0] && pin_strong_o[0]);
  endproperty
  a_strong_both: assert property (p_strong_both) else $error("strong drive wrong");

  property p_sense_high;
    @(posedge clk_i) disable iff (rst_i)
      (s_q.cfg[0][F_SNS_HI:F_SNS_LO] == SNS_HIGH) |-> (det_live[0] == s_q.sync2[0]);
  endproperty
  a_sense_high: assert property (p_sense_high) else $error("high sense wrong");

  property p_sense_low;
    @(posedge clk_i) disable iff (rst_i)
      (s_q.cfg[1][F_SNS_HI:F_SNS_LO] == SNS_LOW) |-> (det_live[1] == !s_q.sync2[1]);
  endproperty
  a_sense_low: assert property (p_sense_low) else $error("low sense wrong");

  property p_pull_down;
    @(posedge clk_i) disable iff (rst_i)
      (s_q.cfg[0][F_PULL_HI:F_PULL_LO] == PULL_DOWN)
      |-> (pin_pull_down_o[0] && !pin_pull_up_o[0]);
  endproperty
  a_pull_down: assert property (p_pull_down) else $error("pull-down wrong");
endmodule // gpio_sense_top

//--- tb/pin_partner.sv
// behavioural model of the pads and the board wiring around the port
// assumes the pad controls come straight from the block, one bit per pin
module pin_partner
  import gpio_sense_pkg::*;
(
  // pad controls from the block
  input  wire logic [NUM_PINS-1:0] oe_i,
  input  wire logic [NUM_PINS-1:0] out_i,
  input  wire logic [NUM_PINS-1:0] pull_up_i,
  input  wire logic [NUM_PINS-1:0] pull_down_i,
  // level the board puts on a floating pin
  input  wire logic [NUM_PINS-1:0] ext_i,
  // resolved pin level back to the block
  output logic      [NUM_PINS-1:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // a driven pad wins; a released pad shows its pull, else the board level,
  // so a stale driven value never lingers on a released pin
  always_comb begin
    for (int n = 0; n < NUM_PINS; n++) begin
      if (oe_i[n])
        pin_o[n] = out_i[n];
      else if (pull_up_i[n])
        pin_o[n] = 1'b1;
      else if (pull_down_i[n])
        pin_o[n] = 1'b0;
      else
        pin_o[n] = ext_i[n];
    end
  end
endmodule // pin_partner

//--- tb/test_gpio_sense_top.sv
// self-checking bench for the gpio configuration and sense latch block
// assumes an avalon-mm master here and the pad model on the pin side
module test_gpio_sense_top
  import gpio_sense_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic                clk_i = 1'b0;    // 25 MHz system clock
  logic                rst_i = 1'b1;    // synchronous reset
  logic                ce_i  = 1'b1;    // enable, on except in the clock enable test
  logic [11:0]         address_i = 12'h000;
  logic                read_i = 1'b0;
  logic                write_i = 1'b0;
  logic [3:0]          byteenable_i = 4'hF;  // full words only
  logic [31:0]         writedata_i = 32'h0000_0000;
  logic [31:0]         readdata_o;
  logic                waitrequest_o;
  logic [NUM_PINS-1:0] pin_i, pin_oe_o, pin_strong_o, pin_pull_up_o, pin_pull_down_o;
  logic [NUM_PINS-1:0] pin_inbuf_en_o;
  logic [NUM_PINS-1:0] pin_out_i = 32'h0000_0000;  // output values per pin
  logic [NUM_PINS-1:0] ext = 32'h0000_0000;        // board level of floating pins
  logic                detect_o, irq_o;
  int                  error_cnt = 0;
  int                  comparisons = 0;
  logic [15:0]         seed = 16'h001B;            // lfsr state, starts at 27
  logic [31:0]         v;
  gpio_sense_top u_gpio_sense_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .address_i(address_i), .read_i(read_i), .write_i(write_i),
    .byteenable_i(byteenable_i), .writedata_i(writedata_i), .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o), .pin_i(pin_i), .pin_out_i(pin_out_i),
    .pin_oe_o(pin_oe_o), .pin_strong_o(pin_strong_o), .pin_pull_up_o(pin_pull_up_o),
    .pin_pull_down_o(pin_pull_down_o), .pin_inbuf_en_o(pin_inbuf_en_o),
    .detect_o(detect_o), .irq_o(irq_o));
  pin_partner u_pin_partner (.oe_i(pin_oe_o), .out_i(pin_out_i), .pull_up_i(pin_pull_up_o),
    .pull_down_i(pin_pull_down_o), .ext_i(ext), .pin_o(pin_i));
  // clock: half period 20 ns
  always #20 clk_i = ~clk_i;
  // verdict and end of run, the only exit
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // single compare point; a four-state mismatch counts as failure
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one avalon-mm access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge clk_i);
    address_i   <= a;
    writedata_i <= d;
    write_i     <= wr;
    read_i      <= ~wr;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (waitrequest_o !== 1'b0 && n < 50);
    q = readdata_o;
    write_i <= 1'b0;
    read_i  <= 1'b0;
    if (n >= 50) begin
      chk(32'h0000_0001, 32'h0000_0000);
      report_and_stop();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(q, exp);
  endtask
  // bounded wait for the detect output to reach a level
  task automatic wait_det(input logic lvl);
    int n;
    n = 0;
    while (detect_o !== lvl && n < 30) begin
      @(posedge clk_i);
      n++;
    end
    chk(detect_o, lvl);
    // a level that never came ends the run at the one exit
    if (detect_o !== lvl) report_and_stop();
  endtask
  // sixteen-bit lfsr for the random configuration words
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // expected {driven, strong} of an output pin for a drive code and level
  function automatic logic [1:0] drv_exp(input logic [2:0] d, input logic l);
    logic oe;
    oe = l ? !(d inside {3'h6, 3'h7}) : !(d inside {3'h4, 3'h5});
    return {oe, oe & (l ? (d inside {3'h2, 3'h3, 3'h5}) : (d inside {3'h1, 3'h3, 3'h7}))};
  endfunction
  // main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(ADDR_CFG0, CFG_RESET);
    rchk(ADDR_CFG1, CFG_RESET);
    rchk(ADDR_LATCH, ZERO32);
    rchk(ADDR_DETMODE, ZERO32);
    rchk(12'h7FC, ZERO32);
    chk(pin_inbuf_en_o[1:0], 2'h0);
    $display("reset values done");
    // one direction bit seen through two registers
    wr(ADDR_DIR, 32'h0000_0002);
    rchk(ADDR_CFG1, 32'h0000_0003);
    wr(ADDR_CFG0, 32'h0000_0001);
    rchk(ADDR_DIR, 32'h0000_0003);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      v = {seed, lfsr(seed)} & 32'hFFFC_FFFF;
      pin_out_i <= {seed, seed};
      wr(ADDR_CFG1, v);
      rchk(ADDR_CFG1, v & (CFG_MASK | 32'h0000_0001));
      rchk(ADDR_DIR, {30'h0, v[0], 1'b1});
    end
    $display("direction sharing done");
    // every drive code at both output levels
    for (int i = 0; i < 8; i++) begin
      for (int l = 0; l < 2; l++) begin
        pin_out_i[0] <= l[0];
        wr(ADDR_CFG0, {21'h0, i[2:0], 8'h01});
        @(posedge clk_i);
        chk({pin_oe_o[0], pin_oe_o[0] & pin_strong_o[0]}, drv_exp(i[2:0], l[0]));
      end
    end
    wr(ADDR_CFG0, 32'h0000_0300);
    chk(pin_oe_o[0], 1'b0);
    $display("drive codes done");
    // every pull code, buffer off then on
    for (int p = 0; p < 4; p++) begin
      wr(ADDR_CFG0, {28'h0, p[1:0], 2'h2});
      chk({pin_pull_up_o[0], pin_pull_down_o[0]}, {p == 3, p == 1});
      chk(pin_inbuf_en_o[0], 1'b0);
    end
    wr(ADDR_CFG0, 32'h0000_0000);
    chk(pin_inbuf_en_o[0], 1'b1);
    $display("pull and buffer done");
    // live detect and latch on pin 0, high sense
    wr(ADDR_CFG1, 32'h0000_0000);
    wr(ADDR_IRQ_ST, 32'h0000_0003);
    wr(ADDR_CFG0, 32'h0002_0000);
    ext <= 32'hFFFF_FFFC;
    wait_det(1'b0);
    ext[0] <= 1'b1;
    wait_det(1'b1);
    rchk(ADDR_LATCH, 32'h0000_0001);
    ext[0] <= 1'b0;
    wait_det(1'b0);
    rchk(ADDR_LATCH, 32'h0000_0001);
    wr(ADDR_LATCH, 32'hFFFF_FFFE);
    rchk(ADDR_LATCH, 32'h0000_0001);
    rchk(ADDR_IRQ_ST, 32'h0000_0003);
    // interrupt masking and clearing
    wr(ADDR_IRQ_MSK, 32'h0000_0000);
    chk(irq_o, 1'b0);
    wr(ADDR_IRQ_MSK, 32'h0000_0002);
    chk(irq_o, 1'b1);
    wr(ADDR_IRQ_ST, 32'h0000_0003);
    chk(irq_o, 1'b0);
    wr(ADDR_LATCH, 32'h0000_0001);
    rchk(ADDR_LATCH, ZERO32);
    $display("live detect done");
    // latched mode holds detect until software clears
    wr(ADDR_DETMODE, 32'h0000_0001);
    ext[0] <= 1'b1;
    wait_det(1'b1);
    ext[0] <= 1'b0;
    repeat (10) @(posedge clk_i);
    chk(detect_o, 1'b1);
    wr(ADDR_LATCH, 32'h0000_0001);
    wait_det(1'b0);
    // low sense on pin 1, then sensing off
    wr(ADDR_CFG1, 32'h0003_0000);
    ext[1] <= 1'b1;
    repeat (6) @(posedge clk_i);
    wr(ADDR_LATCH, 32'h0000_0002);
    rchk(ADDR_LATCH, ZERO32);
    ext[1] <= 1'b0;
    repeat (6) @(posedge clk_i);
    rchk(ADDR_LATCH, 32'h0000_0002);
    wr(ADDR_CFG1, 32'h0000_0000);
    wr(ADDR_LATCH, 32'h0000_0002);
    ext[1] <= 1'b1;
    repeat (6) @(posedge clk_i);
    ext[1] <= 1'b0;
    repeat (6) @(posedge clk_i);
    rchk(ADDR_LATCH, ZERO32);
    chk(detect_o, 1'b0);
    $display("latched detect done");
    // enable low freezes synchroniser and latch, then sensing resumes
    ce_i   <= 1'b0;
    ext[0] <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk(detect_o, 1'b0);
    ce_i   <= 1'b1;
    wait_det(1'b1);
    rchk(ADDR_LATCH, 32'h0000_0001);
    $display("clock enable done");
    report_and_stop();
  end
endmodule // test_gpio_sense_top
